// ==== design/ipb_consts.svh ====
// Constants for the addressing support register block
`ifndef IPB_CONSTS_SVH
`define IPB_CONSTS_SVH
`define IPB_A_PORT0 8'h00
`define IPB_A_SEC0PTR 8'h01
`define IPB_A_PORT1 8'h02
`define IPB_A_WP1L 8'h03
`define IPB_A_WP1S 8'h04
`define IPB_A_ACC 8'h05
`define IPB_A_PC_LOW 8'h06
`define IPB_A_TBLL 8'h07
`define IPB_A_TBDH 8'h08
`define IPB_A_TBPH 8'h09
`define IPB_A_BANK 8'h0B
`define IPB_A_PORT2 8'h0C
`define IPB_A_WP2L 8'h0D
`define IPB_A_WP2S 8'h0E
`define IPB_ZERO 8'h00
`define IPB_BANK_BIT 0
`define IPB_SEC_BIT 8
`define IPB_RESET_BYTE 8'h00
`endif

// ==== design/ipb_pkg.sv ====
// Types for the addressing support register block
`default_nettype none
package ipb_pkg;
    // Core access request: one byte access to data memory
    typedef struct packed {
        logic rd;
        logic wr;
        logic ext;
        logic [8:0] addr;
        logic [7:0] wdata;
    } ipb_req_s;
    // Resolved data memory access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [8:0] addr;
        logic [7:0] wdata;
    } ipb_mem_s;
endpackage
`default_nettype wire

// ==== design/ipb_regs.sv ====
// Pointer, bank, accumulator, pc-low and table registers of the core
`timescale 1ns/1ps
`default_nettype none
`include "ipb_consts.svh"
module ipb_regs
    import ipb_pkg::*;
#(
    parameter int SEC_W = 1,
    parameter int PC_W = 13
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire ipb_req_s req,
    input wire logic [7:0] mem_rdata,
    input wire logic alu_we,
    input wire logic [7:0] alu_result,
    input wire logic tbl_rd,
    input wire logic [15:0] prog_word,
    output ipb_mem_s mem,
    output logic [7:0] rdata,
    output logic [7:0] acc,
    output logic bank_select_bit,
    output logic pc_jump,
    output logic [PC_W-1:0] pc_target,
    output logic dummy_cycle,
    output logic [15:0] tbl_addr
);
    logic [7:0] sector0_pointer;
    logic [7:0] wide_pointer1_low;
    logic [7:0] wide_pointer1_sector;
    logic [7:0] wide_pointer2_low;
    logic [7:0] wide_pointer2_sector;
    logic [7:0] table_ptr_low;
    logic [7:0] table_ptr_high;
    logic [7:0] table_data_high;
    logic [PC_W-1:0] pc;
    logic is_sfr;
    logic [7:0] loc;
    logic wr_sfr;
    ipb_mem_s next_mem;
    logic [7:0] next_rdata;
    logic mem_rd_q;
    logic [7:0] wr_byte;
    logic we_s0p;
    logic we_p1l;
    logic we_p1s;
    logic we_p2l;
    logic we_p2s;
    logic we_acc;
    logic we_pc_low;
    logic we_tpl;
    logic we_tdh;
    logic we_tph;
    logic we_bank;

    ////////////////////////////////////////////////////////////////////////
    // Address resolution
    assign loc = req.addr[7:0];
    // Plain forms address sector 0 directly; the extended form and ports 1 and 2, which follow their wide pointers, can leave it
    assign is_sfr = (!req.ext || !req.addr[`IPB_SEC_BIT]) && (loc <= `IPB_A_WP2S);
    // A table read stores its low byte like an ordinary write
    assign wr_sfr = (req.wr || tbl_rd) && is_sfr;
    assign wr_byte = tbl_rd ? prog_word[7:0] : req.wdata;

    // Redirect port accesses through their pointers
    always_comb begin
        next_mem.rd = req.rd && !tbl_rd;
        next_mem.wr = req.wr || tbl_rd;
        next_mem.wdata = wr_byte;
        // Extended form carries the sector above the location
        next_mem.addr = req.ext ? req.addr : {1'b0, loc};
        if (!req.ext || !req.addr[`IPB_SEC_BIT]) begin
            unique case (loc)
                `IPB_A_PORT0: next_mem.addr = {1'b0, sector0_pointer};
                `IPB_A_PORT1: next_mem.addr = {wide_pointer1_sector[0], wide_pointer1_low};
                `IPB_A_PORT2: next_mem.addr = {wide_pointer2_sector[0], wide_pointer2_low};
                default: begin
                    // Other special locations are registers, not memory; a table
                    // read naming one must not clobber the byte behind it
                    if (is_sfr) begin
                        next_mem.rd = 1'b0;
                        next_mem.wr = 1'b0;
                    end
                end
            endcase
        end
    end

    // Registered memory strobes; outputs come from flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem <= '0;
        end else begin
            mem <= next_mem;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One strobe per stored register; ports and unused codes strobe nothing,
    // so a write naming a port leaves every register alone
    always_comb begin
        we_s0p = 1'b0;
        we_p1l = 1'b0;
        we_p1s = 1'b0;
        we_p2l = 1'b0;
        we_p2s = 1'b0;
        we_acc = 1'b0;
        we_pc_low = 1'b0;
        we_tpl = 1'b0;
        we_tdh = 1'b0;
        we_tph = 1'b0;
        we_bank = 1'b0;
        if (wr_sfr) begin
            unique case (loc)
                `IPB_A_SEC0PTR: we_s0p = 1'b1;
                `IPB_A_WP1L: we_p1l = 1'b1;
                `IPB_A_WP1S: we_p1s = 1'b1;
                `IPB_A_WP2L: we_p2l = 1'b1;
                `IPB_A_WP2S: we_p2s = 1'b1;
                `IPB_A_ACC: we_acc = 1'b1;
                `IPB_A_PC_LOW: we_pc_low = 1'b1;
                `IPB_A_TBLL: we_tpl = 1'b1;
                `IPB_A_TBDH: we_tdh = 1'b1;
                `IPB_A_TBPH: we_tph = 1'b1;
                `IPB_A_BANK: we_bank = 1'b1;
                default: ;
            endcase
        end
    end

    // Sector 0 pointer: ordinary storage, any instruction may modify it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sector0_pointer <= `IPB_RESET_BYTE;
        end else if (we_s0p) begin
            sector0_pointer <= wr_byte;
        end
    end

    // Wide pointer 1, location byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wide_pointer1_low <= `IPB_RESET_BYTE;
        end else if (we_p1l) begin
            wide_pointer1_low <= wr_byte;
        end
    end

    // Wide pointer 1, sector byte; only its low bit reaches the address
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wide_pointer1_sector <= `IPB_RESET_BYTE;
        end else if (we_p1s) begin
            wide_pointer1_sector <= wr_byte;
        end
    end

    // Wide pointer 2, location byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wide_pointer2_low <= `IPB_RESET_BYTE;
        end else if (we_p2l) begin
            wide_pointer2_low <= wr_byte;
        end
    end

    // Wide pointer 2, sector byte; full byte kept so software reads it back
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wide_pointer2_sector <= `IPB_RESET_BYTE;
        end else if (we_p2s) begin
            wide_pointer2_sector <= wr_byte;
        end
    end

    // Program bank select, only bit 0 is stored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_select_bit <= 1'b0;
        end else if (we_bank) begin
            bank_select_bit <= wr_byte[`IPB_BANK_BIT];
        end
    end

    // Accumulator: ALU result wins over a bus write in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= `IPB_RESET_BYTE;
        end else if (alu_we) begin
            acc <= alu_result;
        end else if (we_acc) begin
            acc <= wr_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table pointer low byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            table_ptr_low <= `IPB_RESET_BYTE;
        end else if (we_tpl) begin
            table_ptr_low <= wr_byte;
        end
    end

    // Table pointer high byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            table_ptr_high <= `IPB_RESET_BYTE;
        end else if (we_tph) begin
            table_ptr_high <= wr_byte;
        end
    end

    // Captured high byte; the fetched word wins over a plain write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            table_data_high <= `IPB_RESET_BYTE;
        end else if (tbl_rd) begin
            table_data_high <= prog_word[15:8];
        end else if (we_tdh) begin
            table_data_high <= wr_byte;
        end
    end

    // Table address presented from flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tbl_addr <= '0;
        end else begin
            tbl_addr <= {table_ptr_high, table_ptr_low};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pc low byte; the page bits above it are never touched by the write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc <= '0;
        end else if (we_pc_low) begin
            pc <= {pc[PC_W-1:8], wr_byte};
        end
    end

    // Jump target stays inside the current page
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_target <= '0;
        end else if (we_pc_low) begin
            pc_target <= {pc[PC_W-1:8], wr_byte};
        end
    end

    // Jump request lasts exactly one cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_jump <= 1'b0;
        end else begin
            pc_jump <= we_pc_low;
        end
    end

    // Dummy cycle trails the jump so the prefetched word is thrown away
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dummy_cycle <= 1'b0;
        end else begin
            dummy_cycle <= pc_jump;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; ports and unused locations read zero
    always_comb begin
        next_rdata = `IPB_ZERO;
        if (req.rd && is_sfr) begin
            unique case (loc)
                `IPB_A_SEC0PTR: next_rdata = sector0_pointer;
                `IPB_A_WP1L: next_rdata = wide_pointer1_low;
                `IPB_A_WP1S: next_rdata = wide_pointer1_sector;
                `IPB_A_WP2L: next_rdata = wide_pointer2_low;
                `IPB_A_WP2S: next_rdata = wide_pointer2_sector;
                `IPB_A_ACC: next_rdata = acc;
                `IPB_A_PC_LOW: next_rdata = pc[7:0];
                `IPB_A_TBLL: next_rdata = table_ptr_low;
                `IPB_A_TBDH: next_rdata = table_data_high;
                `IPB_A_TBPH: next_rdata = table_ptr_high;
                `IPB_A_BANK: next_rdata = {7'h00, bank_select_bit};
                default: next_rdata = `IPB_ZERO;
            endcase
        end
    end

    // Read strobe delayed to line up with the memory's data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_rd_q <= 1'b0;
        end else begin
            mem_rd_q <= next_mem.rd;
        end
    end

    // Memory data for redirected reads arrives one cycle later; a request
    // in that cycle loses its answer, so the core must not issue one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= `IPB_ZERO;
        end else begin
            rdata <= mem_rd_q ? mem_rdata : next_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== tb/ipb_regs_sva.sv ====
// Port assertions for the addressing register block
`timescale 1ns/1ps
`default_nettype none
`include "ipb_consts.svh"
module ipb_regs_sva
    import ipb_pkg::*;
#(parameter int PC_W = 13) (
    input wire logic clk,
    input wire logic rst_b,
    input wire ipb_req_s req,
    input wire logic alu_we,
    input wire logic [7:0] alu_result,
    input wire logic tbl_rd,
    input wire logic [15:0] prog_word,
    input wire ipb_mem_s mem,
    input wire logic [7:0] rdata,
    input wire logic [7:0] acc,
    input wire logic bank_select_bit,
    input wire logic pc_jump,
    input wire logic [PC_W-1:0] pc_target,
    input wire logic dummy_cycle
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Sector 1 direct hits never land on special registers
    logic sfr;
    logic bwr;
    logic [7:0] wd;
    logic [7:0] pw;
    logic [8:0] ra;
    assign sfr = !(req.ext && req.addr[8]);
    assign bwr = req.wr && sfr && req.addr[7:0] == `IPB_A_BANK;
    assign wd = req.wdata;
    assign pw = prog_word[7:0];
    assign ra = req.addr;
    a_pc_jump: assert property (req.wr && !tbl_rd && sfr && req.addr[7:0] == `IPB_A_PC_LOW
        |=> pc_jump && pc_target[7:0] == $past(wd)) else $error("pc low write lost");
    a_dummy_next: assert property (pc_jump |=> dummy_cycle) else $error("no dummy");
    a_dummy_cause: assert property (dummy_cycle |-> $past(pc_jump)) else $error("stray dummy");
    a_ext_direct: assert property (req.wr && !tbl_rd && !sfr
        |=> mem.wr && mem.addr == $past(ra) && mem.wdata == $past(wd)) else $error("ext write wrong");
    a_port0_sector: assert property ((req.rd || req.wr) && sfr && req.addr[7:0] == `IPB_A_PORT0
        |=> (mem.rd || mem.wr) && !mem.addr[8]) else $error("port 0 left sector 0");
    a_bank_set: assert property (bwr |=> bank_select_bit == $past(wd[0])) else $error("bank bit");
    a_bank_keep: assert property (!bwr |=> $stable(bank_select_bit)) else $error("bank moved");
    a_bank_read: assert property (req.rd && !req.wr && bwr == 1'b0 && sfr && ra[7:0] == `IPB_A_BANK
        |=> rdata == {7'h00, bank_select_bit}) else $error("bank upper bits");
    a_acc_load: assert property (alu_we |=> acc == $past(alu_result)) else $error("acc load");
    a_tbl_low: assert property (tbl_rd && (!sfr || ra[7:0] > `IPB_A_WP2S)
        |=> mem.wr && mem.wdata == $past(pw)) else $error("table low");
    a_unused_zero: assert property (req.rd && sfr && ra[7:0] == 8'h0A
        |=> rdata == 8'h00) else $error("unused not zero");
endmodule
bind ipb_regs ipb_regs_sva #(.PC_W(PC_W)) chk (.clk(clk), .rst_b(rst_b), .req(req), .alu_we(alu_we),
    .alu_result(alu_result), .tbl_rd(tbl_rd), .prog_word(prog_word), .mem(mem), .rdata(rdata), .acc(acc),
    .bank_select_bit(bank_select_bit), .pc_jump(pc_jump), .pc_target(pc_target), .dummy_cycle(dummy_cycle));
`default_nettype wire

// ==== tb/ipb_dmem.sv ====
// Data memory model behind the resolved access port
`timescale 1ns/1ps
`default_nettype none
module ipb_dmem
    import ipb_pkg::*;
(
    input wire logic clk,
    input wire ipb_mem_s mem,
    output logic [7:0] mem_rdata
);
    logic [7:0] ram [0:511];
    logic [7:0] junk = 8'h5A;
    // Idle read lines toggle so a late sample is caught
    always @(posedge clk) begin
        if (mem.wr) begin
            ram[mem.addr] <= mem.wdata;
        end
        junk <= ~junk;
    end
    assign mem_rdata = mem.rd ? ram[mem.addr] : junk;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the addressing register block
`timescale 1ns/1ps
`default_nettype none
`include "ipb_consts.svh"
module testbench
    import ipb_pkg::*;
;
    logic clk, rst_b, alu_we, tbl_rd, pc_jump, dummy_cycle, bsel;
    logic [7:0] mem_rdata, alu_result, rdata, acc;
    logic [15:0] prog_word, tbl_addr;
    logic [12:0] pc_target;
    ipb_req_s req;
    ipb_mem_s mem;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    ipb_regs uut (.clk(clk), .rst_b(rst_b), .req(req), .mem_rdata(mem_rdata), .alu_we(alu_we),
        .alu_result(alu_result), .tbl_rd(tbl_rd), .prog_word(prog_word), .mem(mem), .rdata(rdata),
        .acc(acc), .bank_select_bit(bsel), .pc_jump(pc_jump), .pc_target(pc_target),
        .dummy_cycle(dummy_cycle), .tbl_addr(tbl_addr));
    ipb_dmem dmem (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));
    // 100 MHz clock and hang guard
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_sim();
        end
    end
    ////////////////////////////////////////
    task automatic end_sim();
        $display("Tests %0d, failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // One access; idle cycle first so req is never set twice in a step
    task automatic op(input logic r, w, x, input logic [7:0] a, input logic [7:0] d);
        tick();
        req = '{r, w, x, {x, a}, d};
        tick();
        req = '0;
    endtask
    function automatic logic [15:0] mv();
        return {mem.wr, mem.rd, 5'h00, mem.addr};
    endfunction
    ////////////////////////////////////////
    task automatic t_bank();
        chk(bsel, 0);
        op(1, 0, 0, `IPB_A_BANK, 0);
        chk(rdata, 0);
        op(0, 1, 0, `IPB_A_BANK, 8'hFF);
        chk(bsel, 1);
        op(1, 0, 0, `IPB_A_BANK, 0);
        chk(rdata, 16'h0001);
    endtask
    task automatic t_ptr();
        op(0, 1, 0, `IPB_A_SEC0PTR, 8'hF0);
        op(1, 0, 0, `IPB_A_SEC0PTR, 0);
        chk(rdata, 16'h00F0);
        op(0, 1, 0, `IPB_A_PORT0, 8'h33);
        chk(mv(), 16'h80F0);
        chk(mem.wdata, 16'h0033);
        op(1, 0, 0, `IPB_A_SEC0PTR, 0);
        chk(rdata, 16'h00F0);
        op(0, 1, 0, `IPB_A_WP1S, 0);
        op(0, 1, 0, `IPB_A_WP1L, 8'h10);
        op(0, 1, 0, `IPB_A_PORT1, 8'h55);
        chk(mv(), 16'h8010);
    endtask
    task automatic t_ext();
        op(0, 1, 1, 8'hF0, 8'hA5);
        chk(mv(), 16'h81F0);
        op(0, 1, 0, `IPB_A_WP2S, 8'h01);
        op(0, 1, 0, `IPB_A_WP2L, 8'hF0);
        op(1, 0, 0, `IPB_A_PORT2, 0);
        chk(mv(), 16'h41F0);
        tick();
        chk(rdata, 16'h00A5);
        op(1, 0, 0, 8'h0A, 0);
        chk(rdata, 0);
        chk({mem.wr, mem.rd}, 0);
    endtask
    task automatic t_pc_low();
        op(0, 1, 0, `IPB_A_PC_LOW, 8'h3C);
        chk(pc_jump, 1);
        chk(pc_target[7:0], 16'h003C);
        tick();
        chk({pc_jump, dummy_cycle}, 16'h0001);
    endtask
    task automatic t_alu();
        tick();
        alu_we = 1;
        alu_result = 8'h96;
        tick();
        alu_we = 0;
        chk(acc, 16'h0096);
        op(1, 0, 0, `IPB_A_ACC, 0);
        chk(rdata, 16'h0096);
    endtask
    task automatic t_tbl();
        op(0, 1, 0, `IPB_A_TBLL, 8'h34);
        op(0, 1, 0, `IPB_A_TBPH, 8'h12);
        tick();
        chk(tbl_addr, 16'h1234);
        tbl_rd = 1;
        prog_word = 16'hABCD;
        req = '{0, 0, 0, 9'h020, 8'h00};
        tick();
        tbl_rd = 0;
        req = '0;
        chk(mv(), 16'h8020);
        chk(mem.wdata, 16'h00CD);
        op(1, 0, 0, `IPB_A_TBDH, 0);
        chk(rdata, 16'h00AB);
        tick();
        tbl_rd = 1;
        prog_word = 16'h5A3C;
        req = '{0, 0, 0, {1'b0, `IPB_A_ACC}, 8'h00};
        tick();
        tbl_rd = 0;
        req = '0;
        chk({mem.wr, mem.rd}, 0);
        chk(acc, 16'h003C);
    endtask
    // Reset, then each scenario in turn
    initial begin
        {alu_we, tbl_rd, alu_result, prog_word} = '0;
        req = '0;
        rst_b = 0;
        repeat (3) @(posedge clk);
        #1 rst_b = 1;
        t_bank();
        t_ptr();
        t_ext();
        t_pc_low();
        t_alu();
        t_tbl();
        end_sim();
    end
endmodule
`default_nettype wire
